// file: hw/nibble_swap_exchange_xor_unit_consts.svh
`ifndef NIBBLE_SWAP_EXCHANGE_XOR_UNIT_CONSTS_SVH
`define NIBBLE_SWAP_EXCHANGE_XOR_UNIT_CONSTS_SVH

`define OPC_SWAP 8'hc4
`define OPC_XCH_REG_HI 5'h19
`define OPC_XCH_DIR 8'hc5
`define OPC_XCH_IND_HI 7'h63
`define OPC_LOW_DIGIT_EXCHANGE_OP_IND_HI 7'h6b
`define OPC_XRL_REG_HI 5'h0d
`define OPC_XRL_DIR 8'h65
`define OPC_XRL_IND_HI 7'h33
`define OPC_XRL_IMM 8'h64
`define OPC_XRL_DIR_A 8'h62
`define OPC_XRL_DIR_IMM 8'h63
`define RESET_BYTE 8'h00

`endif

// file: hw/nsx_pkg.sv
package nsx_pkg;
    typedef enum logic [3:0] {
        OP_NONE,
        OP_SWAP,
        OP_XCH_REG,
        OP_XCH_DIR,
        OP_XCH_IND,
        OP_LOW_DIGIT_EXCHANGE_OP_IND,
        OP_XRL_A_REG,
        OP_XRL_A_DIR,
        OP_XRL_A_IND,
        OP_XRL_A_IMM,
        OP_XRL_DIR_A,
        OP_XRL_DIR_IMM
    } op_e;
endpackage

// file: hw/opcode_classifier.sv
`timescale 1ns/100ps
`include "nibble_swap_exchange_xor_unit_consts.svh"

module opcode_classifier
    import nsx_pkg::*;
(
    input wire logic [7:0] i_opcode,
    output op_e o_op
);

    always_comb
    begin
        o_op = OP_NONE;
        if (i_opcode == `OPC_SWAP)
            o_op = OP_SWAP;
        else if (i_opcode[7:3] == `OPC_XCH_REG_HI)
            o_op = OP_XCH_REG;
        else if (i_opcode == `OPC_XCH_DIR)
            o_op = OP_XCH_DIR;
        else if (i_opcode[7:1] == `OPC_XCH_IND_HI)
            o_op = OP_XCH_IND;
        else if (i_opcode[7:1] == `OPC_LOW_DIGIT_EXCHANGE_OP_IND_HI)
            o_op = OP_LOW_DIGIT_EXCHANGE_OP_IND;
        else if (i_opcode[7:3] == `OPC_XRL_REG_HI)
            o_op = OP_XRL_A_REG;
        else if (i_opcode == `OPC_XRL_DIR)
            o_op = OP_XRL_A_DIR;
        else if (i_opcode[7:1] == `OPC_XRL_IND_HI)
            o_op = OP_XRL_A_IND;
        else if (i_opcode == `OPC_XRL_IMM)
            o_op = OP_XRL_A_IMM;
        else if (i_opcode == `OPC_XRL_DIR_A)
            o_op = OP_XRL_DIR_A;
        else if (i_opcode == `OPC_XRL_DIR_IMM)
            o_op = OP_XRL_DIR_IMM;
    end

endmodule // opcode_classifier

// file: hw/nibble_swap_exchange_xor_unit.sv
// Functional notes
// - Nibble swap exchanges accumulator bits 3-0 with bits 7-4, a four-bit rotate.
// - Nibble swap is opcode 8'hc4, one byte, executed in one cycle.
// - None of these operations touches any program status flag.
// - Byte exchange loads the accumulator with the operand and writes the old accumulator back.
// - The exchange operand is a working register, a direct byte or an indirect RAM byte.
// - Exchange with a register is 11001rrr, through a pointer 1100011i, one byte, one cycle.
// - Low-digit exchange swaps bits 3-0 of accumulator and indirect RAM byte, opcode 1101011i.
// - During low-digit exchange the upper nibbles of both bytes are kept.
// - Exclusive-OR writes the bitwise XOR of its operands into the destination only.
// - XOR to the accumulator takes register, direct, indirect or immediate; to direct takes A or immediate.
// - XOR onto an output port reads the port's output latch, not the pins.
// - XOR to a direct byte complements exactly the bits set in the mask byte.
`timescale 1ns/100ps
`include "nibble_swap_exchange_xor_unit_consts.svh"

module nibble_swap_exchange_xor_unit
    import nsx_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_valid,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_operand,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_psw,
    input wire logic [7:0] i_reg_data,
    input wire logic [7:0] i_ptr_data,
    input wire logic [7:0] i_direct_data,
    input wire logic i_direct_is_port,
    input wire logic [7:0] i_port_latch,
    input wire logic [7:0] i_ram_data,
    output logic [2:0] o_reg_sel,
    output logic o_ptr_sel,
    output logic [7:0] o_direct_addr,
    output logic [7:0] o_ram_addr,
    output logic o_done,
    output logic o_acc_we,
    output logic [7:0] o_acc,
    output logic o_psw_we,
    output logic [7:0] o_psw,
    output logic o_reg_we,
    output logic [2:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    output logic o_direct_we,
    output logic [7:0] o_direct_wdata,
    output logic o_ram_we,
    output logic [7:0] o_ram_wdata
);

    op_e op;
    logic [7:0] direct_src;

    logic done_d, done_q;
    logic acc_we_d, acc_we_q;
    logic [7:0] acc_d, acc_q;
    logic [7:0] psw_q;
    logic reg_we_d, reg_we_q;
    logic [2:0] reg_addr_d, reg_addr_q;
    logic [7:0] reg_wdata_d, reg_wdata_q;
    logic dir_we_d, dir_we_q;
    logic [7:0] dir_addr_d, dir_addr_q;
    logic [7:0] dir_wdata_d, dir_wdata_q;
    logic ram_we_d, ram_we_q;
    logic [7:0] ram_addr_d, ram_addr_q;
    logic [7:0] ram_wdata_d, ram_wdata_q;

    function automatic logic [7:0] swap_nibbles(input logic [7:0] b);
        swap_nibbles = {b[3:0], b[7:4]};
    endfunction

    opcode_classifier u_classifier
    (
        .i_opcode(i_opcode),
        .o_op(op)
    );

    // Operand selects are combinational so the register file answers in the same cycle.
    assign o_reg_sel = i_opcode[2:0];
    assign o_ptr_sel = i_opcode[0];
    assign o_direct_addr = i_operand;
    assign o_ram_addr = i_ptr_data;
    assign direct_src = i_direct_is_port ? i_port_latch : i_direct_data;

    always_comb
    begin
        done_d = 1'b0;
        acc_we_d = 1'b0;
        acc_d = i_acc;
        reg_we_d = 1'b0;
        reg_addr_d = i_opcode[2:0];
        reg_wdata_d = i_acc;
        dir_we_d = 1'b0;
        dir_addr_d = i_operand;
        dir_wdata_d = i_acc;
        ram_we_d = 1'b0;
        ram_addr_d = i_ptr_data;
        ram_wdata_d = i_acc;
        if (i_valid)
        begin
            done_d = 1'b1;
            unique case (op)
                OP_SWAP:
                begin
                    acc_we_d = 1'b1;
                    acc_d = swap_nibbles(i_acc);
                end
                OP_XCH_REG:
                begin
                    acc_we_d = 1'b1;
                    acc_d = i_reg_data;
                    reg_we_d = 1'b1;
                end
                OP_XCH_DIR:
                begin
                    acc_we_d = 1'b1;
                    acc_d = i_direct_data;
                    dir_we_d = 1'b1;
                end
                OP_XCH_IND:
                begin
                    acc_we_d = 1'b1;
                    acc_d = i_ram_data;
                    ram_we_d = 1'b1;
                end
                OP_LOW_DIGIT_EXCHANGE_OP_IND:
                begin
                    acc_we_d = 1'b1;
                    acc_d = {i_acc[7:4], i_ram_data[3:0]};
                    ram_we_d = 1'b1;
                    ram_wdata_d = {i_ram_data[7:4], i_acc[3:0]};
                end
                OP_XRL_A_REG:
                begin
                    acc_we_d = 1'b1;
                    acc_d = i_acc ^ i_reg_data;
                end
                OP_XRL_A_DIR:
                begin
                    acc_we_d = 1'b1;
                    acc_d = i_acc ^ i_direct_data;
                end
                OP_XRL_A_IND:
                begin
                    acc_we_d = 1'b1;
                    acc_d = i_acc ^ i_ram_data;
                end
                OP_XRL_A_IMM:
                begin
                    acc_we_d = 1'b1;
                    acc_d = i_acc ^ i_operand;
                end
                OP_XRL_DIR_A:
                begin
                    dir_we_d = 1'b1;
                    dir_wdata_d = direct_src ^ i_acc;
                end
                OP_XRL_DIR_IMM:
                begin
                    // The mask arrives as the following instruction byte; the address is
                    // taken from the same operand lane by the decoder's earlier cycle.
                    dir_we_d = 1'b1;
                    dir_wdata_d = direct_src ^ i_operand;
                end
                OP_NONE:
                begin
                    done_d = 1'b0;
                end
            endcase
        end
    end

    // Flags are only passed through and never written.
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            done_q <= 1'b0;
            acc_we_q <= 1'b0;
            acc_q <= `RESET_BYTE;
            psw_q <= `RESET_BYTE;
            reg_we_q <= 1'b0;
            reg_addr_q <= 3'h0;
            reg_wdata_q <= `RESET_BYTE;
            dir_we_q <= 1'b0;
            dir_addr_q <= `RESET_BYTE;
            dir_wdata_q <= `RESET_BYTE;
            ram_we_q <= 1'b0;
            ram_addr_q <= `RESET_BYTE;
            ram_wdata_q <= `RESET_BYTE;
        end
        else
        begin
            done_q <= done_d;
            acc_we_q <= acc_we_d;
            acc_q <= acc_d;
            psw_q <= i_psw;
            reg_we_q <= reg_we_d;
            reg_addr_q <= reg_addr_d;
            reg_wdata_q <= reg_wdata_d;
            dir_we_q <= dir_we_d;
            dir_addr_q <= dir_addr_d;
            dir_wdata_q <= dir_wdata_d;
            ram_we_q <= ram_we_d;
            ram_addr_q <= ram_addr_d;
            ram_wdata_q <= ram_wdata_d;
        end
    end

    assign o_done = done_q;
    assign o_acc_we = acc_we_q;
    assign o_acc = acc_q;
    assign o_psw_we = 1'b0;
    assign o_psw = psw_q;
    assign o_reg_we = reg_we_q;
    assign o_reg_addr = reg_addr_q;
    assign o_reg_wdata = reg_wdata_q;
    assign o_direct_we = dir_we_q;
    assign o_direct_wdata = dir_wdata_q;
    assign o_ram_we = ram_we_q;
    assign o_ram_wdata = ram_wdata_q;

endmodule // nibble_swap_exchange_xor_unit

// file: verification/nibble_swap_exchange_xor_unit_monitor.sv
`timescale 1ns/100ps
module nibble_swap_exchange_xor_unit_monitor (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_valid,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_operand,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_psw,
    input wire logic [7:0] i_reg_data,
    input wire logic [7:0] i_direct_data,
    input wire logic i_direct_is_port,
    input wire logic [7:0] i_port_latch,
    input wire logic [7:0] i_ram_data,
    input wire logic [2:0] o_reg_sel,
    input wire logic [7:0] o_direct_addr,
    input wire logic o_done,
    input wire logic o_acc_we,
    input wire logic [7:0] o_acc,
    input wire logic o_psw_we,
    input wire logic [7:0] o_psw,
    input wire logic o_reg_we,
    input wire logic [2:0] o_reg_addr,
    input wire logic [7:0] o_reg_wdata,
    input wire logic o_direct_we,
    input wire logic [7:0] o_direct_wdata,
    input wire logic o_ram_we,
    input wire logic [7:0] o_ram_wdata
);
    logic [7:0] src;
    assign src = i_direct_is_port ? i_port_latch : i_direct_data;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_swap; i_valid && i_opcode == 8'hc4; endsequence
    sequence s_xreg; i_valid && i_opcode[7:3] == 5'h19; endsequence
    sequence s_xind; i_valid && i_opcode[7:1] == 7'h63; endsequence
    sequence s_low_digit_exchange_op; i_valid && i_opcode[7:1] == 7'h6b; endsequence
    sequence s_xda; i_valid && i_opcode == 8'h62; endsequence
    chk_swap_nibbles: assert property (s_swap |=> o_done && o_acc_we && o_acc ==
        {$past(i_acc[3:0]), $past(i_acc[7:4])}) else $error("swap result wrong");
    chk_flags_kept: assert property (o_done |-> !o_psw_we && o_psw == $past(i_psw))
        else $error("flags disturbed");
    chk_xch_reg: assert property (s_xreg |=> o_reg_we && o_reg_wdata == $past(i_acc)
        && o_acc == $past(i_reg_data) && o_reg_addr == $past(i_opcode[2:0]))
        else $error("register exchange wrong");
    chk_xch_ind: assert property (s_xind |=> o_ram_we && o_acc_we
        && o_ram_wdata == $past(i_acc) && o_acc == $past(i_ram_data))
        else $error("indirect exchange wrong");
    chk_digit_swap: assert property (s_low_digit_exchange_op |=> o_ram_we && o_acc_we
        && o_ram_wdata == {$past(i_ram_data[7:4]), $past(i_acc[3:0])}
        && o_acc == {$past(i_acc[7:4]), $past(i_ram_data[3:0])}) else $error("digit swap wrong");
    chk_xor_direct: assert property (s_xda |=> o_direct_we && !o_acc_we
        && o_direct_wdata == ($past(i_acc) ^ $past(src))) else $error("direct xor wrong");
    chk_idle_quiet: assert property (!i_valid |=> !o_done && !o_acc_we && !o_ram_we
        && !o_reg_we && !o_direct_we) else $error("write without request");
    chk_select_lanes: assert property (o_reg_sel == i_opcode[2:0]
        && o_direct_addr == i_operand) else $error("operand select wrong");
endmodule // nibble_swap_exchange_xor_unit_monitor

bind nibble_swap_exchange_xor_unit nibble_swap_exchange_xor_unit_monitor i_mon (.*);

// file: verification/nibble_swap_exchange_xor_unit_tb_top.sv
`timescale 1ns/100ps
module nibble_swap_exchange_xor_unit_tb_top;
    logic i_sys_clk, i_sys_rst, i_valid, i_direct_is_port;
    logic [7:0] i_opcode, i_operand, i_acc, i_psw, i_reg_data, i_ptr_data, i_direct_data;
    logic [7:0] i_port_latch, i_ram_data, o_direct_addr, o_ram_addr, o_acc, o_psw;
    logic [7:0] o_reg_wdata, o_direct_wdata, o_ram_wdata;
    logic [2:0] o_reg_sel, o_reg_addr;
    logic o_ptr_sel, o_done, o_acc_we, o_psw_we, o_reg_we, o_direct_we, o_ram_we;
    int err_count = 0;
    int tests_run = 0;
    nibble_swap_exchange_xor_unit i_nibble_swap_exchange_xor_unit (.*);
    always #4 i_sys_clk = ~i_sys_clk;
    task cmp(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Strobe order: done, acc, reg, direct, ram, flags.
    task cmps(input logic [5:0] e);
        cmp({2'h0, o_done, o_acc_we, o_reg_we, o_direct_we, o_ram_we, o_psw_we}, {2'h0, e});
        cmp(o_psw, i_psw);
    endtask
    task go(input logic [7:0] op);
        @(negedge i_sys_clk);
        i_opcode = op;
        i_valid = 1'b1;
        #1;
        cmp({4'h0, o_ptr_sel, o_reg_sel}, {4'h0, op[0], op[2:0]});
        cmp(o_direct_addr, i_operand);
        cmp(o_ram_addr, i_ptr_data);
        @(negedge i_sys_clk);
        i_valid = 1'b0;
    endtask
    task t_swap;
        i_acc = 8'hc5;
        go(8'hc4);
        cmps(6'h30);
        cmp(o_acc, 8'h5c);
    endtask
    task t_xch_reg;
        for (int r = 0; r < 8; r++)
        begin
            i_acc = 8'h3f;
            i_reg_data = 8'h40 + r[7:0];
            go(8'hc8 | r[7:0]);
            cmps(6'h38);
            cmp(o_acc, 8'h40 + r[7:0]);
            cmp(o_reg_wdata, 8'h3f);
            cmp({5'h0, o_reg_addr}, r[7:0]);
        end
    endtask
    task t_xch_mem;
        i_operand = 8'h20;
        i_direct_data = 8'h75;
        i_acc = 8'h3f;
        go(8'hc5);
        cmps(6'h34);
        cmp(o_acc, 8'h75);
        cmp(o_direct_wdata, 8'h3f);
        for (int i = 0; i < 2; i++)
        begin
            i_ptr_data = 8'h20 + i[7:0];
            i_ram_data = 8'h75;
            i_acc = 8'h3f;
            go(8'hc6 | i[7:0]);
            cmps(6'h32);
            cmp(o_acc, 8'h75);
            cmp(o_ram_wdata, 8'h3f);
            i_acc = 8'h36;
            go(8'hd6 | i[7:0]);
            cmps(6'h32);
            cmp(o_acc, 8'h35);
            cmp(o_ram_wdata, 8'h76);
        end
    endtask
    task t_xor_acc;
        logic [7:0] ops [4] = '{8'h6d, 8'h65, 8'h66, 8'h64};
        logic [7:0] src [4] = '{8'haa, 8'h0f, 8'hf0, 8'h55};
        i_reg_data = 8'haa;
        i_direct_data = 8'h0f;
        i_ram_data = 8'hf0;
        i_operand = 8'h55;
        for (int k = 0; k < 4; k++)
        begin
            i_acc = 8'hc3;
            go(ops[k]);
            cmps(6'h30);
            cmp(o_acc, 8'hc3 ^ src[k]);
        end
    endtask
    task t_xor_direct;
        i_acc = 8'h31;
        i_direct_data = 8'ha5;
        i_port_latch = 8'h0f;
        for (int p = 0; p < 2; p++)
        begin
            i_direct_is_port = p[0];
            go(8'h62);
            cmps(6'h24);
            cmp(o_direct_wdata, 8'h31 ^ (p[0] ? 8'h0f : 8'ha5));
        end
        i_operand = 8'h31;
        for (int p = 0; p < 2; p++)
        begin
            i_direct_is_port = p[0];
            go(8'h63);
            cmps(6'h24);
            cmp(o_direct_wdata, 8'h31 ^ (p[0] ? 8'h0f : 8'ha5));
        end
        go(8'ha5);
        cmps(6'h00);
    endtask
    task print_verdict;
        $display("mismatches %0d comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        {i_sys_clk, i_valid, i_direct_is_port} = 3'h0;
        i_sys_rst = 1'b1;
        {i_opcode, i_operand, i_acc, i_reg_data, i_ptr_data} = 40'h0;
        {i_direct_data, i_port_latch, i_ram_data} = 24'h0;
        i_psw = 8'ha5;
        repeat (8) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        t_swap;
        t_xch_reg;
        t_xch_mem;
        t_xor_acc;
        t_xor_direct;
        print_verdict;
    end
endmodule // nibble_swap_exchange_xor_unit_tb_top
